// ===== timer_pwm_pkg.sv
`default_nettype none

package timer_pwm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_CH_BASE = 8'h10;
    localparam logic [7:0] OFS_CH_STRIDE = 8'h08;
    localparam logic [7:0] OFS_CH_VALUE = 8'h04;

    // Control register fields
    localparam int CTRL_CLK_SEL_LSB = 0;
    localparam int CTRL_CENTER = 2;
    localparam int CTRL_OVF_IE = 3;
    localparam int CTRL_OVF_FLAG = 8;

    // Channel control fields
    localparam int CH_EL_LO = 0;
    localparam int CH_EL_HI = 1;
    localparam int CH_KIND_LO = 2;
    localparam int CH_KIND_HI = 3;
    localparam int CH_IE = 4;
    localparam int CH_FLAG = 7;

    // Values after reset
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [15:0] RST_CH_VALUE = 16'h0000;
    localparam logic [1:0] RST_CLK_SEL = 2'h0;

    // Counter width and channel limits
    localparam int COUNT_W = 16;
    localparam int MAX_CH = 8;

    // Channel behaviour, one-hot
    typedef enum logic [3:0] {
        MODE_CAPTURE = 4'b0001,
        MODE_COMPARE = 4'b0010,
        MODE_EDGE = 4'b0100,
        MODE_CENTER = 4'b1000
    } ch_mode_t;

    // Counting direction, one-hot
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } cnt_dir_t;

endpackage

`default_nettype wire

// ===== timer_pwm_unit.sv
// Function
// - Compare without pin control still flags match
// - Edge PWM when center off, kind 1:0
// - Edge period is limit plus one ticks
// - Edge PWM flags at end of pulse
// - PWM with level bits 0:0 leaves pin
// - Edge 1:0 high at overflow, low at match
// - Edge X:1 low at overflow, high at match
// - Edge value zero 0%, above limit 100%
// - Center PWM counts up then down
// - Center width twice value, period twice limit
// - Center PWM flags match both directions
// - Center 1:0 high down-match, low up-match
// - Center X:1 low down-match, high up-match
// - Center value zero 0%, above limit 100%
// - Period write immediate stopped, else at overflow
// - Value write timing depends on channel mode
// - Counter trigger from overflow until next tick
// - Channel pre-trigger then trigger, both drop
// - Reset leaves unit stopped, outputs zero
// - Overflow flag set at limit turnaround
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_unit
    import timer_pwm_pkg::*;
#(
    parameter int NUM_CH = 2
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NUM_CH-1:0] ch_out,
    output logic [NUM_CH-1:0] ch_oe,
    output logic overflow_irq,
    output logic [NUM_CH-1:0] ch_irq,
    output logic counter_trigger,
    output logic [NUM_CH-1:0] ch_pretrigger,
    output logic [NUM_CH-1:0] ch_trigger
);

    // Channel registers must fit below the byte address space
    initial
    begin
        if (NUM_CH < 1 || NUM_CH > MAX_CH)
            $error("NUM_CH out of range");
    end

    // Decode the behaviour of one channel from its kind bits
    function automatic ch_mode_t decode_mode(input logic center, input logic hi, input logic lo);
        if (center && hi && !lo)
            return MODE_CENTER;
        else if (!center && hi && !lo)
            return MODE_EDGE;
        else if (!center && lo)
            return MODE_COMPARE;
        else
            return MODE_CAPTURE;
    endfunction

    // PWM active level; center mode is also active at the down-count match, so width is twice the value
    function automatic logic pwm_active(input logic center, input cnt_dir_t d, input logic [COUNT_W-1:0] cnt,
        input logic [COUNT_W-1:0] val);
        return (cnt < val) || (center && d == DIR_DOWN && cnt == val);
    endfunction

    // Channel address slot, NUM_CH when the offset is no channel
    function automatic int ch_slot(input logic [7:0] addr);
        int idx;
        idx = NUM_CH;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (addr[7:3] == 5'((OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE) >> 3))
                idx = i;
        end
        return idx;
    endfunction

    // Global control and status
    logic [1:0] counter_clock_select;
    logic center_align_select;
    logic overflow_irq_enable;
    logic overflow_flag;
    logic [COUNT_W-1:0] count;
    cnt_dir_t dir;
    logic [COUNT_W-1:0] period_limit;
    logic [COUNT_W-1:0] period_buf;
    logic period_pending;

    // Per-channel control, value and flag
    logic [NUM_CH-1:0] edge_level_lo;
    logic [NUM_CH-1:0] edge_level_hi;
    logic [NUM_CH-1:0] channel_kind_lo;
    logic [NUM_CH-1:0] channel_kind_hi;
    logic [NUM_CH-1:0] channel_irq_enable;
    logic [NUM_CH-1:0] channel_flag;
    logic [COUNT_W-1:0] channel_value [NUM_CH];
    logic [COUNT_W-1:0] value_buf [NUM_CH];
    logic [NUM_CH-1:0] value_pending;

    // Bus strobes: data moves only on the edge where pready is seen high
    logic bus_done;
    logic wr_en;
    int wr_slot;
    assign bus_done = psel && penable && pready;
    assign wr_en = bus_done && pwrite;
    assign wr_slot = ch_slot(paddr);

    // Counter events
    logic running;
    logic tick;
    logic overflow_evt;
    logic [COUNT_W-1:0] next_count;
    cnt_dir_t next_dir;
    assign running = (counter_clock_select != RST_CLK_SEL);
    // Prescaler lies outside this block, so every enabled clock is a tick
    assign tick = running;

    // Next counter value and turnaround
    always_comb
    begin
        next_count = count;
        next_dir = dir;
        overflow_evt = 1'b0;
        if (tick)
        begin
            if (!center_align_select)
            begin
                // Up counting, period_limit + 1 ticks
                if (count == period_limit)
                begin
                    next_count = RST_COUNT;
                    overflow_evt = 1'b1;
                end
                else
                    next_count = count + 16'h0001;
                next_dir = DIR_UP;
            end
            else
            begin
                // Up-down counting, 2 x period_limit ticks
                case (dir)
                    DIR_UP:
                    begin
                        if (count >= period_limit)
                        begin
                            next_count = period_limit - 16'h0001;
                            next_dir = DIR_DOWN;
                            overflow_evt = 1'b1;
                        end
                        else
                            next_count = count + 16'h0001;
                    end
                    DIR_DOWN:
                    begin
                        if (count == RST_COUNT || count == 16'h0001)
                            next_dir = DIR_UP;
                        next_count = (count == RST_COUNT) ? 16'h0001 : count - 16'h0001;
                    end
                    default:
                    begin
                        next_count = RST_COUNT;
                        next_dir = DIR_UP;
                    end
                endcase
            end
        end
    end

    // Counter and direction state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= RST_COUNT;
            dir <= DIR_UP;
        end
        else
        begin
            count <= next_count;
            dir <= next_dir;
        end
    end

    // Global control register written from the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_clock_select <= RST_CLK_SEL;
            center_align_select <= 1'b0;
            overflow_irq_enable <= 1'b0;
        end
        else if (wr_en && paddr == OFS_CTRL)
        begin
            counter_clock_select <= pwdata[CTRL_CLK_SEL_LSB +: 2];
            center_align_select <= pwdata[CTRL_CENTER];
            overflow_irq_enable <= pwdata[CTRL_OVF_IE];
        end
    end

    // Overflow flag: hardware set beats a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            overflow_flag <= 1'b0;
        else if (overflow_evt)
            overflow_flag <= 1'b1;
        else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_OVF_FLAG])
            overflow_flag <= 1'b0;
    end

    // Period limit with its write buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            period_limit <= RST_PERIOD;
            period_buf <= RST_PERIOD;
            period_pending <= 1'b0;
        end
        else if (wr_en && paddr == OFS_PERIOD)
        begin
            period_buf <= pwdata[COUNT_W-1:0];
            // Stopped counter takes the value at once
            if (!running)
                period_limit <= pwdata[COUNT_W-1:0];
            period_pending <= running;
        end
        else if (period_pending && overflow_evt)
        begin
            // Held until limit-to-zero or limit-to-limit-minus-one
            period_limit <= period_buf;
            period_pending <= 1'b0;
        end
        else if (!running)
        begin
            period_limit <= period_buf;
            period_pending <= 1'b0;
        end
    end

    // Channel behaviour decoded once per channel
    ch_mode_t mode [NUM_CH];
    logic [NUM_CH-1:0] match;
    logic [NUM_CH-1:0] flag_evt;
    always_comb
    begin
        for (int n = 0; n < NUM_CH; n++)
        begin
            mode[n] = decode_mode(center_align_select, channel_kind_hi[n], channel_kind_lo[n]);
            match[n] = tick && (count == channel_value[n]);
            case (mode[n])
                MODE_COMPARE: flag_evt[n] = match[n];
                MODE_EDGE: flag_evt[n] = match[n];
                // Value above limit still flags at the turnaround
                MODE_CENTER: flag_evt[n] = match[n] ||
                    (overflow_evt && channel_value[n] > period_limit);
                default: flag_evt[n] = 1'b0;
            endcase
        end
    end

    // Channel control register and flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            edge_level_lo <= '0;
            edge_level_hi <= '0;
            channel_kind_lo <= '0;
            channel_kind_hi <= '0;
            channel_irq_enable <= '0;
            channel_flag <= '0;
        end
        else
        begin
            for (int n = 0; n < NUM_CH; n++)
            begin
                if (wr_en && wr_slot == n && paddr[2:0] == 3'h0)
                begin
                    edge_level_lo[n] <= pwdata[CH_EL_LO];
                    edge_level_hi[n] <= pwdata[CH_EL_HI];
                    channel_kind_lo[n] <= pwdata[CH_KIND_LO];
                    channel_kind_hi[n] <= pwdata[CH_KIND_HI];
                    channel_irq_enable[n] <= pwdata[CH_IE];
                end
                // Set wins over the write-one clear
                if (flag_evt[n])
                    channel_flag[n] <= 1'b1;
                else if (wr_en && wr_slot == n && paddr[2:0] == 3'h0 && pwdata[CH_FLAG])
                    channel_flag[n] <= 1'b0;
            end
        end
    end

    // Channel value with its write buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            value_pending <= '0;
            for (int n = 0; n < NUM_CH; n++)
            begin
                channel_value[n] <= RST_CH_VALUE;
                value_buf[n] <= RST_CH_VALUE;
            end
        end
        else
        begin
            for (int n = 0; n < NUM_CH; n++)
            begin
                // Capture channels ignore value writes
                if (wr_en && wr_slot == n && paddr[2:0] == OFS_CH_VALUE[2:0] && mode[n] != MODE_CAPTURE)
                begin
                    value_buf[n] <= pwdata[COUNT_W-1:0];
                    value_pending[n] <= running;
                    if (!running)
                        channel_value[n] <= pwdata[COUNT_W-1:0];
                end
                else if (value_pending[n])
                begin
                    // Compare takes it next tick, PWM at the turnaround
                    if ((mode[n] == MODE_COMPARE && tick) || overflow_evt || !running)
                    begin
                        channel_value[n] <= value_buf[n];
                        value_pending[n] <= 1'b0;
                    end
                end
            end
        end
    end

    // Channel pins; level compare keeps 0% and 100% free of glitches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch_out <= '0;
            ch_oe <= '0;
        end
        else
        begin
            for (int n = 0; n < NUM_CH; n++)
            begin
                // Pin released when both level bits are clear
                ch_oe[n] <= (edge_level_hi[n] || edge_level_lo[n]) && mode[n] != MODE_CAPTURE;
                case (mode[n])
                    MODE_EDGE, MODE_CENTER:
                    begin
                        // High from overflow or down-match until the match
                        if (edge_level_lo[n])
                            ch_out[n] <= !pwm_active(mode[n] == MODE_CENTER, next_dir, next_count,
                                channel_value[n]);
                        else if (edge_level_hi[n])
                            ch_out[n] <= pwm_active(mode[n] == MODE_CENTER, next_dir, next_count,
                                channel_value[n]);
                    end
                    MODE_COMPARE:
                    begin
                        if (match[n])
                        begin
                            case ({edge_level_hi[n], edge_level_lo[n]})
                                2'b01: ch_out[n] <= !ch_out[n];
                                2'b10: ch_out[n] <= 1'b0;
                                2'b11: ch_out[n] <= 1'b1;
                                default: ch_out[n] <= ch_out[n];
                            endcase
                        end
                    end
                    default: ch_out[n] <= ch_out[n];
                endcase
            end
        end
    end

    // Interrupt lines need both enable and flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overflow_irq <= 1'b0;
            ch_irq <= '0;
        end
        else
        begin
            overflow_irq <= overflow_irq_enable && overflow_flag;
            ch_irq <= channel_irq_enable & channel_flag;
        end
    end

    // Output triggers for other peripherals
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_trigger <= 1'b0;
            ch_pretrigger <= '0;
            ch_trigger <= '0;
        end
        else
        begin
            if (overflow_evt)
                counter_trigger <= 1'b1;
            else if (tick)
                counter_trigger <= 1'b0;
            for (int n = 0; n < NUM_CH; n++)
            begin
                if (tick && ch_trigger[n])
                begin
                    ch_trigger[n] <= 1'b0;
                    ch_pretrigger[n] <= flag_evt[n];
                end
                else if (tick && ch_pretrigger[n])
                    ch_trigger[n] <= 1'b1;
                else if (flag_evt[n])
                    ch_pretrigger[n] <= 1'b1;
            end
        end
    end

    // Read data mux
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (paddr == OFS_CTRL)
        begin
            next_rdata[CTRL_CLK_SEL_LSB +: 2] = counter_clock_select;
            next_rdata[CTRL_CENTER] = center_align_select;
            next_rdata[CTRL_OVF_IE] = overflow_irq_enable;
            next_rdata[CTRL_OVF_FLAG] = overflow_flag;
        end
        else if (paddr == OFS_COUNT)
            next_rdata[COUNT_W-1:0] = count;
        else if (paddr == OFS_PERIOD)
            next_rdata[COUNT_W-1:0] = period_limit;
        else
        begin
            for (int n = 0; n < NUM_CH; n++)
            begin
                if (wr_slot == n && paddr[2:0] == 3'h0)
                begin
                    next_rdata[CH_EL_LO] = edge_level_lo[n];
                    next_rdata[CH_EL_HI] = edge_level_hi[n];
                    next_rdata[CH_KIND_LO] = channel_kind_lo[n];
                    next_rdata[CH_KIND_HI] = channel_kind_hi[n];
                    next_rdata[CH_IE] = channel_irq_enable[n];
                    next_rdata[CH_FLAG] = channel_flag[n];
                end
                else if (wr_slot == n && paddr[2:0] == OFS_CH_VALUE[2:0])
                    next_rdata[COUNT_W-1:0] = channel_value[n];
            end
        end
    end

    // Decoded address, for the error answer
    logic addr_ok;
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_COUNT) || (paddr == OFS_PERIOD) ||
        (wr_slot < NUM_CH && (paddr[2:0] == 3'h0 || paddr[2:0] == OFS_CH_VALUE[2:0]));

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Checks
    sequence s_ovf_up;
        tick && !center_align_select && count == period_limit;
    endsequence

    sequence s_ovf_center;
        tick && center_align_select && dir == DIR_UP && count >= period_limit;
    endsequence

    AST_EDGE_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        s_ovf_up |=> count == RST_COUNT)
        else $error("edge counter did not wrap to zero");

    AST_OVF_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ovf_up or s_ovf_center) |=> overflow_flag && counter_trigger)
        else $error("overflow flag or trigger missing");

    AST_CENTER_TURN: assert property (@(posedge pclk) disable iff (!presetn)
        s_ovf_center |=> dir == DIR_DOWN && count == $past(period_limit) - 16'h0001)
        else $error("center counter did not turn down");

    AST_OVF_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        overflow_flag && !(wr_en && paddr == OFS_CTRL) |=> overflow_flag)
        else $error("overflow flag dropped without clear");

    AST_CH_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        flag_evt[0] |=> channel_flag[0] ##1 ch_irq[0] == channel_irq_enable[0])
        else $error("channel flag or interrupt wrong");

    AST_PERIOD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        running && wr_en && paddr == OFS_PERIOD && !overflow_evt |=> period_limit == $past(period_limit))
        else $error("period changed before turnaround");

    AST_TRIG_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
        tick && ch_pretrigger[0] && !ch_trigger[0] |=> ch_trigger[0] ##1 (!ch_trigger[0] || !$past(tick)))
        else $error("channel trigger sequence wrong");

    AST_CNT_TRIG_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        counter_trigger && tick && !overflow_evt |=> !counter_trigger)
        else $error("counter trigger stuck");

    AST_PIN_FREE: assert property (@(posedge pclk) disable iff (!presetn)
        !edge_level_hi[0] && !edge_level_lo[0] |=> !ch_oe[0])
        else $error("pin driven with level bits clear");

    AST_EDGE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        mode[0] == MODE_EDGE && edge_level_hi[0] && !edge_level_lo[0] && channel_value[0] == RST_CH_VALUE
        |=> !ch_out[0])
        else $error("zero value gave a pulse");

endmodule

`default_nettype wire

// ===== pin_watch.sv
`timescale 1ns/1ps
`default_nettype none

// Far side of the channel pins and trigger inputs of neighbouring peripherals
module pin_watch
#(
    parameter int NUM_CH = 2
)(
    input wire logic pclk,
    input wire logic en,
    input wire logic [NUM_CH-1:0] ch_out,
    input wire logic [NUM_CH-1:0] ch_oe,
    input wire logic counter_trigger,
    input wire logic [NUM_CH-1:0] ch_trigger,
    output int hcnt0,
    output int hcnt1,
    output int ctr,
    output int chtr
);
    logic ctr_d = 1'b0; // Last counter trigger level
    logic chtr_d = 1'b0; // Last channel 0 trigger level
    // Pins have pull-downs, so an undriven pin reads low
    always_ff @(posedge pclk)
    begin
        ctr_d <= counter_trigger;
        chtr_d <= ch_trigger[0];
        if (!en)
        begin
            hcnt0 <= 0;
            hcnt1 <= 0;
            ctr <= 0;
            chtr <= 0;
        end
        else
        begin
            hcnt0 <= hcnt0 + int'(ch_oe[0] & ch_out[0]);
            hcnt1 <= hcnt1 + int'(ch_oe[1] & ch_out[1]);
            // Rising edges only, a receiver acts once per assertion
            ctr <= ctr + int'(counter_trigger & !ctr_d);
            chtr <= chtr + int'(ch_trigger[0] & !chtr_d);
        end
    end
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import timer_pwm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic en = 1'b0; // Measurement window of the pin model
    logic [31:0] prdata;
    logic pready, pslverr, overflow_irq, counter_trigger;
    logic [1:0] ch_out, ch_oe, ch_irq, ch_pretrigger, ch_trigger;
    logic [31:0] rdat; // Last read data
    logic rerr; // Last error response
    int hcnt0, hcnt1, ctr, chtr, miscompares, n_compared, lim, v, per, hi, md, seed;
    localparam logic [7:0] CH0 = OFS_CH_BASE;
    localparam logic [7:0] CH1 = OFS_CH_BASE + OFS_CH_STRIDE;

    timer_pwm_unit #(.NUM_CH(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch_out(ch_out), .ch_oe(ch_oe), .overflow_irq(overflow_irq), .ch_irq(ch_irq),
        .counter_trigger(counter_trigger), .ch_pretrigger(ch_pretrigger), .ch_trigger(ch_trigger));
    pin_watch #(.NUM_CH(2)) pins_u (.pclk(pclk), .en(en), .ch_out(ch_out), .ch_oe(ch_oe),
        .counter_trigger(counter_trigger), .ch_trigger(ch_trigger), .hcnt0(hcnt0), .hcnt1(hcnt1),
        .ctr(ctr), .chtr(chtr));

    // 50 MHz clock
    initial
    begin
        forever #10 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Single comparison point, four-state exact
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // APB transfer; an edge passes first so psel is never driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // Sample pready at each rising edge; data and response are taken at that same edge
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            miscompares++;
            stop_test();
        end
    endtask

    // Count pin activity over exactly n edges
    task automatic meas(input int n);
        @(posedge pclk);
        en <= 1'b1;
        repeat (n) @(posedge pclk);
        en <= 1'b0;
        @(negedge pclk);
    endtask

    initial
    begin
        seed = $urandom(32'h3788422f);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("outputs", 32'({ch_out, ch_oe, ch_irq, overflow_irq, counter_trigger}), 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", rdat, 32'h0);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk("count", rdat, 32'(RST_COUNT));
        apb(1'b0, OFS_PERIOD, 32'h0);
        chk("period", rdat, 32'(RST_PERIOD));
        apb(1'b0, 8'hf0, 32'h0);
        chk("unmapped", 32'(rerr), 32'h1);
        // Edge then center PWM with a random duty; the model is plain arithmetic
        for (md = 0; md < 2; md++)
        begin
            lim = md ? 4 : 5;
            v = 1 + int'($urandom % (lim - 1));
            per = md ? 2 * lim : lim + 1;
            hi = md ? 2 * v : v;
            apb(1'b1, OFS_PERIOD, 32'(lim));
            apb(1'b1, CH0, 32'h1a);
            apb(1'b1, CH0 + OFS_CH_VALUE, 32'(v));
            apb(1'b1, CH1, 32'h09);
            apb(1'b1, CH1 + OFS_CH_VALUE, 32'(v));
            apb(1'b1, OFS_CTRL, 32'(9 + 4 * md));
            repeat (3 * per) @(posedge pclk);
            meas(2 * per);
            chk("high ch0", 32'(hcnt0), 32'(2 * hi));
            chk("high ch1", 32'(hcnt1), 32'(2 * (per - hi)));
            chk("ovf trig", 32'(ctr), 32'h2);
            chk("ch trig", 32'(chtr), md ? 32'h4 : 32'h2);
            chk("irq", 32'({overflow_irq, ch_irq[0], ch_oe}), 32'hf);
            // Stop first so no overflow can race the clear, then clear both flags
            apb(1'b1, OFS_CTRL, 32'(8 + 4 * md));
            apb(1'b1, OFS_CTRL, 32'(32'h108 + 4 * md));
            apb(1'b1, CH0, 32'h9a);
            repeat (2) @(negedge pclk);
            chk("irq clr", 32'({overflow_irq, ch_irq[0]}), 32'h0);
        end
        // Duty extremes: zero value and value above the limit
        for (md = 0; md < 2; md++)
        begin
            per = md ? 8 : 6;
            apb(1'b1, CH1 + OFS_CH_VALUE, 32'h7);
            apb(1'b1, CH0 + OFS_CH_VALUE, 32'h0);
            apb(1'b1, CH1, 32'h9a);
            apb(1'b1, OFS_CTRL, 32'(1 + 4 * md));
            repeat (2 * per) @(posedge pclk);
            meas(2 * per);
            chk("zero duty", 32'(hcnt0), 32'h0);
            chk("full duty", 32'(hcnt1), 32'(2 * per));
            apb(1'b0, CH1, 32'h0);
            chk("ch1 flag", 32'(rdat[CH_FLAG]), 32'(md));
            apb(1'b1, OFS_CTRL, 32'h100);
        end
        // Compare with level bits 0:0 flags but never drives the pin
        apb(1'b1, CH0, 32'h94);
        apb(1'b1, CH0 + OFS_CH_VALUE, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_PERIOD, 32'h3);
        repeat (12) @(posedge pclk);
        @(negedge pclk);
        chk("cmp pin", 32'({ch_oe[0], ch_irq[0]}), 32'h1);
        apb(1'b0, OFS_PERIOD, 32'h0);
        chk("period upd", rdat, 32'h3);
        stop_test();
    end
endmodule

`default_nettype wire
